// >>> src/cfb_params.svh
// Constants for the core/fabric boundary block
`ifndef CFB_PARAMS_SVH
`define CFB_PARAMS_SVH
`define CFB_READY_HOLD_CYCLES 6
`define CFB_CHANNELS 4
`define CFB_CPU_ADDR_W 7
`define CFB_CPU_DATA_W 8
`define CFB_RECOVERED_CLK_MHZ 77.76
`define CFB_RX_MARK_PERIOD 16
`endif

// >>> src/cfb_pkg.sv
// Types shared by the core/fabric boundary block
package cfb_pkg;
    typedef struct packed {
        logic [6:0] addr;
        logic rd_wr_n;
        logic cs_n;
        logic [7:0] wdata;
    } cfb_cpu_req_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic int_n;
    } cfb_cpu_rsp_t;
    typedef enum logic [1:0] {
        CFB_ST_CONFIG,
        CFB_ST_HOLD,
        CFB_ST_READY
    } cfb_ready_state_t;
endpackage : cfb_pkg

// >>> src/cfb_ready_seq.sv
// Core-ready sequencer: holds the flag low after configuration
`timescale 1ns/100ps
`include "cfb_params.svh"
module cfb_ready_seq #(
    parameter int HOLD = `CFB_READY_HOLD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic config_done,
    output logic core_ready
);
    cfb_pkg::cfb_ready_state_t state;
    cfb_pkg::cfb_ready_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_core_ready;

    // Next state of the hold sequence
    always_comb begin
        next_state = state;
        next_count = count;
        next_core_ready = 1'b0;
        unique case (state)
            cfb_pkg::CFB_ST_CONFIG: begin
                next_count = 4'h0;
                if (config_done) begin
                    next_state = cfb_pkg::CFB_ST_HOLD; // see R1
                end
            end
            cfb_pkg::CFB_ST_HOLD: begin
                next_count = count + 4'h1;
                if (count == 4'(HOLD - 1)) begin
                    next_state = cfb_pkg::CFB_ST_READY; // see R2
                    next_core_ready = 1'b1;
                end
            end
            cfb_pkg::CFB_ST_READY: begin
                next_core_ready = 1'b1; // see R3
            end
            // Unused code falls back to the configuration wait
            default: begin
                next_state = cfb_pkg::CFB_ST_CONFIG;
                next_count = 4'h0;
            end
        endcase
    end

    // Registers of the hold sequence
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= cfb_pkg::CFB_ST_CONFIG;
            count <= 4'h0;
            core_ready <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            core_ready <= next_core_ready;
        end
    end
endmodule : cfb_ready_seq

// >>> src/cfb_boundary.sv
// Core/fabric boundary: host bridge, overhead link marks, frame marks
`timescale 1ns/100ps
`include "cfb_params.svh"
// What this block does
// R1: Core-ready stays low during power-up and fabric configuration.
// R2: After configuration ends, core-ready stays low six cycles then rises.
// R3: Core-ready high means the core has left reset.
// R4: Host bus source select 0 takes core pins, 1 takes the fabric bridge.
// R5: A soft bit gates the receive overhead clock-qualify and frame mark.
// R6: Channel A overhead enable is channel A enable AND its output drive.
// R7: A receive overhead frame mark is given to the fabric.
// R8: A receive overhead clock qualify tells the fabric when to sample.
// R9: The alignment FIFO gives one frame mark for all four channels.
// R10: Each channel gives its own recovered byte clock to the fabric.
// R11: Fabric bridge drives address, strobe, select, data; gets data, irq.
// R12: Fabric drives a transmit frame mark into the core.
// R13: Fabric drives a receive frame mark into the core.
// R14: Core reset resets only the core, never the fabric logic.
module cfb_boundary #(
    parameter int CHANNELS = `CFB_CHANNELS,
    parameter int MARK_PERIOD = `CFB_RX_MARK_PERIOD
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic config_done,
    output logic core_ready,
    input wire logic host_bus_source_select,
    input wire cfb_pkg::cfb_cpu_req_t pin_cpu_req,
    output cfb_pkg::cfb_cpu_rsp_t pin_cpu_rsp,
    input wire cfb_pkg::cfb_cpu_req_t fabric_cpu_req,
    output cfb_pkg::cfb_cpu_rsp_t fabric_cpu_rsp,
    output cfb_pkg::cfb_cpu_req_t core_cpu_req,
    input wire cfb_pkg::cfb_cpu_rsp_t core_cpu_rsp,
    input wire logic rx_overhead_clk_pulse_gate,
    output logic rx_overhead_clk_pulse_gate_out,
    input wire logic chan_a_enable,
    input wire logic chan_a_drive_enable,
    output logic rx_overhead_enable_a,
    input wire logic rx_overhead_bit_valid,
    input wire logic rx_overhead_frame_start,
    output logic rx_overhead_link_clk_qualify,
    output logic rx_overhead_link_frame_mark,
    input wire logic [CHANNELS-1:0] chan_frame_found,
    output logic aligned_frame_mark,
    input wire logic [CHANNELS-1:0] recovered_clk_in,
    output logic [CHANNELS-1:0] recovered_byte_clk,
    input wire logic transmit_frame_mark,
    input wire logic receive_frame_mark,
    output logic core_transmit_frame_mark,
    output logic core_receive_frame_mark
);
    logic gate;
    logic next_gate;
    logic qualify;
    logic next_qualify;
    logic mark;
    logic next_mark;
    logic ena;
    logic next_ena;
    logic [CHANNELS-1:0] seen;
    logic [CHANNELS-1:0] next_seen;
    logic aligned;
    logic next_aligned;
    logic txm;
    logic next_txm;
    logic rxm;
    logic next_rxm;

    // Core-ready sequence after configuration
    cfb_ready_seq #(
        .HOLD(`CFB_READY_HOLD_CYCLES)
    ) u_ready (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .config_done(config_done),
        .core_ready(core_ready)
    );

    // Host bus steering between core pins and fabric bridge
    always_comb begin
        core_cpu_req = host_bus_source_select ? fabric_cpu_req
                                              : pin_cpu_req; // see R4
        pin_cpu_rsp = '{rdata: 8'h00, int_n: 1'b1};
        fabric_cpu_rsp = '{rdata: 8'h00, int_n: 1'b1};
        if (host_bus_source_select) begin
            fabric_cpu_rsp = core_cpu_rsp; // see R11
        end else begin
            pin_cpu_rsp = core_cpu_rsp;
        end
    end

    // Gates an overhead input by the registered soft enable.
    // Used for both the clock qualify and the frame mark, so the
    // two outputs can never disagree about the gate.
    function automatic logic cfb_gate_in(
        input logic en,
        input logic sig
    );
        return en & sig;
    endfunction : cfb_gate_in

    // Next values of the overhead link group.
    // The gate is taken from the soft bit one cycle late; the
    // qualify and frame mark use the registered copy, so they
    // follow the soft bit two cycles after it rises.
    always_comb begin
        next_gate = rx_overhead_clk_pulse_gate; // see R5
        next_ena = chan_a_enable & chan_a_drive_enable; // see R6
        next_qualify = cfb_gate_in(gate, rx_overhead_bit_valid); // see R8
        next_mark = cfb_gate_in(gate, rx_overhead_frame_start); // see R7
    end

    // Registers of the overhead link group; fabric reset only
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin // see R14
            gate <= 1'b0;
            ena <= 1'b0;
            qualify <= 1'b0;
            mark <= 1'b0;
        end else begin
            gate <= next_gate;
            ena <= next_ena;
            qualify <= next_qualify;
            mark <= next_mark;
        end
    end

    // Next values of the alignment group.
    // Each channel's found pulse is kept sticky until all four
    // have been seen; then one mark is given and the collection
    // starts again. A found pulse in the same cycle as the last
    // missing one still counts toward the current frame.
    always_comb begin
        next_seen = seen | chan_frame_found;
        next_aligned = 1'b0;
        if (&next_seen) begin
            next_aligned = 1'b1; // see R9
            next_seen = '0;
        end
    end

    // Registers of the alignment group; fabric reset only
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin // see R14
            seen <= '0;
            aligned <= 1'b0;
        end else begin
            seen <= next_seen;
            aligned <= next_aligned;
        end
    end

    // Next values of the fabric frame mark group.
    // Both marks are retimed once on their way into the core so
    // the core sees them on a clean register output.
    always_comb begin
        next_txm = transmit_frame_mark; // see R12
        next_rxm = receive_frame_mark; // see R13
    end

    // Registers of the fabric frame mark group; fabric reset only
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin // see R14
            txm <= 1'b0;
            rxm <= 1'b0;
        end else begin
            txm <= next_txm;
            rxm <= next_rxm;
        end
    end

    // Register copies driven out to the ports

    assign rx_overhead_clk_pulse_gate_out = gate;
    assign rx_overhead_enable_a = ena;
    assign rx_overhead_link_clk_qualify = qualify;
    assign rx_overhead_link_frame_mark = mark;
    assign aligned_frame_mark = aligned;
    assign core_transmit_frame_mark = txm;
    assign core_receive_frame_mark = rxm;

    // Per-channel recovered clocks passed out separately
    for (genvar i = 0; i < CHANNELS; i++) begin : g_clk
        assign recovered_byte_clk[i] = recovered_clk_in[i]; // see R10
    end
endmodule : cfb_boundary

// >>> tb/cfb_core_model.sv
// Behavioural core answering host bus requests
`timescale 1ns/100ps
module cfb_core_model (
    input wire cfb_pkg::cfb_cpu_req_t req,
    output cfb_pkg::cfb_cpu_rsp_t rsp
);
    // Idle data bus floats to its pull-up; reads echo address
    assign rsp.rdata = req.cs_n ? 8'hFF : {1'h1, req.addr};
    // Interrupt low on a selected access with data bit 7 set
    assign rsp.int_n = req.cs_n | ~req.wdata[7];
endmodule : cfb_core_model

// >>> tb/cfb_boundary_assertions.sv
// Checker for the core/fabric boundary ports
`timescale 1ns/100ps
module cfb_boundary_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic config_done,
    input wire logic core_ready,
    input wire logic host_bus_source_select,
    input wire cfb_pkg::cfb_cpu_req_t pin_cpu_req,
    input wire cfb_pkg::cfb_cpu_req_t fabric_cpu_req,
    input wire cfb_pkg::cfb_cpu_req_t core_cpu_req,
    input wire cfb_pkg::cfb_cpu_rsp_t fabric_cpu_rsp,
    input wire cfb_pkg::cfb_cpu_rsp_t core_cpu_rsp,
    input wire logic rx_overhead_clk_pulse_gate_out,
    input wire logic rx_overhead_bit_valid,
    input wire logic rx_overhead_frame_start,
    input wire logic rx_overhead_link_clk_qualify,
    input wire logic rx_overhead_link_frame_mark,
    input wire logic chan_a_enable,
    input wire logic chan_a_drive_enable,
    input wire logic rx_overhead_enable_a,
    input wire logic transmit_frame_mark,
    input wire logic core_transmit_frame_mark,
    input wire logic receive_frame_mark,
    input wire logic core_receive_frame_mark,
    input wire cfb_pkg::cfb_cpu_rsp_t pin_cpu_rsp
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Ready flag sequencing
    property p_cfg; !config_done && !core_ready |=> !core_ready; endproperty
    a_cfg: assert property (p_cfg) else $error("ready early");
    property p_hold;
        $rose(config_done) && !core_ready |=> !core_ready[*6] ##1 core_ready;
    endproperty
    a_hold: assert property (p_hold) else $error("ready timing");
    // Host bus routing
    property p_req; core_cpu_req ==
        (host_bus_source_select ? fabric_cpu_req : pin_cpu_req); endproperty
    a_req: assert property (p_req) else $error("bad req route");
    property p_rsp; fabric_cpu_rsp ==
        (host_bus_source_select ? core_cpu_rsp : 9'h001); endproperty
    a_rsp: assert property (p_rsp) else $error("bad rsp route");
    // Registered outputs one cycle behind, qualify and frame mark gated; then pin response routing
    property p_qual; $past(rstn) |-> rx_overhead_link_clk_qualify ==
        $past(rx_overhead_bit_valid && rx_overhead_clk_pulse_gate_out);
    endproperty
    a_qual: assert property (p_qual) else $error("bad qualify");
    property p_fm; $past(rstn) |-> rx_overhead_link_frame_mark ==
        $past(rx_overhead_frame_start && rx_overhead_clk_pulse_gate_out);
    endproperty
    a_fm: assert property (p_fm) else $error("bad frame mark");
    property p_ena; $past(rstn) |-> rx_overhead_enable_a ==
        $past(chan_a_enable && chan_a_drive_enable); endproperty
    a_ena: assert property (p_ena) else $error("bad enable a");
    property p_tx; $past(rstn) |->
        core_transmit_frame_mark == $past(transmit_frame_mark); endproperty
    a_tx: assert property (p_tx) else $error("bad tx mark");
    property p_rxm; $past(rstn) |->
        core_receive_frame_mark == $past(receive_frame_mark); endproperty
    a_rxm: assert property (p_rxm) else $error("bad rx mark");
    property p_pin; pin_cpu_rsp ==
        (host_bus_source_select ? 9'h001 : core_cpu_rsp); endproperty
    a_pin: assert property (p_pin) else $error("bad pin rsp");
    // Main scenarios reached
    c_rdy: cover property ($rose(core_ready));
    c_fab: cover property (host_bus_source_select && !core_cpu_req.cs_n);
    c_q: cover property (rx_overhead_link_clk_qualify);
endmodule : cfb_boundary_chk
bind cfb_boundary cfb_boundary_chk u_chk (.*);

// >>> tb/tb_cfb_boundary.sv
// Self-checking bench for the core/fabric boundary block
`timescale 1ns/100ps
module tb_cfb_boundary;
    logic clk_sys = 1'h0, rstn = 1'h0, config_done = 1'h0, core_ready;
    logic host_bus_source_select = 1'h0, rx_overhead_clk_pulse_gate = 1'h0;
    logic chan_a_enable = 1'h0, chan_a_drive_enable = 1'h0;
    logic rx_overhead_bit_valid = 1'h0, rx_overhead_frame_start = 1'h0;
    logic transmit_frame_mark = 1'h0, receive_frame_mark = 1'h0;
    logic rx_overhead_clk_pulse_gate_out, rx_overhead_enable_a;
    logic rx_overhead_link_clk_qualify, rx_overhead_link_frame_mark;
    logic aligned_frame_mark, core_transmit_frame_mark;
    logic core_receive_frame_mark;
    logic [3:0] chan_frame_found = 4'h0, recovered_clk_in = 4'h0;
    logic [3:0] recovered_byte_clk;
    cfb_pkg::cfb_cpu_req_t pin_cpu_req = '0, fabric_cpu_req = '0;
    cfb_pkg::cfb_cpu_req_t core_cpu_req;
    cfb_pkg::cfb_cpu_rsp_t pin_cpu_rsp, fabric_cpu_rsp, core_cpu_rsp;
    int n_fail = 0, cmp_count = 0;
    cfb_boundary u_dut (.*);
    cfb_core_model u_core (.req(core_cpu_req), .rsp(core_cpu_rsp));
    always #5 clk_sys = ~clk_sys;
    // Compare and count
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // Ready flag after configuration
    task automatic t_ready();
        cyc(5);
        chk(core_ready, 1'h0);
        config_done = 1'h1;
        cyc(6);
        chk(core_ready, 1'h0);
        cyc(1);
        chk(core_ready, 1'h1);
    endtask : t_ready
    // Both host bus sources
    task automatic t_bus();
        pin_cpu_req = {7'h15, 2'h2, 8'h00};
        fabric_cpu_req = {7'h2A, 2'h2, 8'h80};
        cyc(1);
        chk(core_cpu_req, pin_cpu_req);
        chk(pin_cpu_rsp, 9'h12B);
        chk(fabric_cpu_rsp, 9'h001);
        host_bus_source_select = 1'h1;
        cyc(1);
        chk(core_cpu_req, fabric_cpu_req);
        chk(fabric_cpu_rsp, 9'h154);
        chk(pin_cpu_rsp, 9'h001);
    endtask : t_bus
    // Overhead gating, enable, frame marks, clocks
    task automatic t_links();
        {rx_overhead_bit_valid, rx_overhead_frame_start} = 2'h3;
        {transmit_frame_mark, recovered_clk_in} = 5'h1A;
        cyc(2);
        chk({rx_overhead_link_clk_qualify, rx_overhead_link_frame_mark}, 2'h0);
        chk({core_transmit_frame_mark, recovered_byte_clk}, 5'h1A);
        {rx_overhead_clk_pulse_gate, transmit_frame_mark} = 2'h2;
        receive_frame_mark = 1'h1;
        cyc(1);
        chk({rx_overhead_link_clk_qualify, core_receive_frame_mark}, 2'h1);
        cyc(1);
        chk({rx_overhead_link_clk_qualify, rx_overhead_link_frame_mark}, 2'h3);
        rx_overhead_frame_start = 1'h0;
        cyc(1);
        chk({rx_overhead_link_frame_mark, core_transmit_frame_mark}, 2'h0);
        for (int i = 0; i < 4; i++) begin
            {chan_a_enable, chan_a_drive_enable} = i[1:0];
            cyc(1);
            chk(rx_overhead_enable_a, i == 3);
        end
    endtask : t_links
    // Frame mark only once all four channels are found
    task automatic t_align();
        int k;
        for (k = 0; k < 3; k++) begin
            chan_frame_found = 4'h1 << k;
            cyc(2);
            chk(aligned_frame_mark, 1'h0);
        end
        chan_frame_found = 4'h8;
        cyc(1);
        chan_frame_found = 4'h0;
        for (k = 0; k < 3 && aligned_frame_mark !== 1'h1; k++) cyc(1);
        chk(aligned_frame_mark, 1'h1);
        cyc(1);
        chk(aligned_frame_mark, 1'h0);
    endtask : t_align
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(12);
        rstn = 1'h1;
        t_ready();
        t_bus();
        t_links();
        t_align();
        tally_and_finish();
    end
endmodule : tb_cfb_boundary
